/* File: logic/dwpc_pkg.sv */
// constants and types shared by the dual wiper position control block
//
// Function
// - inbound bits sampled on serial clock rise; outbound bit changes after its fall
// - serial data only pulled low or released, open-drain style
// - four strap pins give the low nibble of the 8-bit slave address
// - command proceeds only when received address matches the strap levels
// - write-guard low blocks every nonvolatile stored setting write
// - 8-bit wiper position decodes to exactly one of 256 taps
// - never more than one tap on per channel, even during changes
// - two independent channels, each with own wiper control and terminals
// - per channel one wiper position and four stored settings, all host accessible
// - at power-up each wiper position loads from stored setting slot zero
// - host writes and reads wiper position directly
// - acknowledge matching address, command byte, and a following data byte
// - address acknowledge withheld during 5ms nonvolatile write; master polls
// - two slot select bits pick stored setting slot zero to three
package dwpc_pkg;

   // ==========================================================
   // geometry
   localparam int NUM_CH   = 2;
   localparam int NUM_SLOT = 4;
   localparam int NUM_TAP  = 256;

   // ==========================================================
   // timing
   localparam int CLK_MHZ          = 40;
   localparam int NV_WRITE_TIME_US = 5000;
   localparam int NV_WRITE_CYCLES  = NV_WRITE_TIME_US * CLK_MHZ;

   // ==========================================================
   // reset values
   localparam logic [7:0] DR_RESET  = 8'h00;
   localparam logic [7:0] WCR_RESET = 8'h00;

   // ==========================================================
   // instruction byte fields
   localparam int OP_MSB   = 7;
   localparam int OP_LSB   = 4;
   localparam int SLOT_MSB = 3;
   localparam int SLOT_LSB = 2;
   localparam int ZERO_BIT = 1;
   localparam int POT_BIT  = 0;
   localparam int BYTE_BITS = 8;

   typedef enum logic [3:0] {
      OP_G_DR_TO_WCR = 4'h1,
      OP_G_WCR_TO_DR = 4'h8,
      OP_RD_WCR      = 4'h9,
      OP_WR_WCR      = 4'ha,
      OP_RD_DR       = 4'hb,
      OP_WR_DR       = 4'hc,
      OP_DR_TO_WCR   = 4'hd,
      OP_WCR_TO_DR   = 4'he
   } dwpc_op_t;

   typedef enum logic [2:0] {
      L_IDLE  = 3'b000,
      L_ADDR  = 3'b001,
      L_INSTR = 3'b010,
      L_DRX   = 3'b011,
      L_TX    = 3'b100,
      L_IGN   = 3'b101
   } dwpc_lst_t;

endpackage

/* File: logic/dwpc_tap_decode.sv */
// one-hot tap switch decoder with break-before-make
`timescale 1ns/1ps
module dwpc_tap_decode
   import dwpc_pkg::*;
(
   input  wire logic               clk_sys,   // system clock
   input  wire logic               rst,       // sync reset
   input  wire logic               ce,        // clock enable
   input  wire logic [7:0]         position,  // wiper position
   output logic      [NUM_TAP-1:0] tap_on     // one-hot tap switches
);

   typedef struct packed {
      logic [7:0]         cur;
      logic               gap;
      logic [NUM_TAP-1:0] tap;
   } dwpc_tap_t;

   dwpc_tap_t s_q;
   dwpc_tap_t s_d;

   // a change first opens all switches for one cycle, then closes the new one
   always_comb begin
      s_d = s_q;
      if (rst) begin
         s_d.cur = WCR_RESET;
         s_d.gap = 1'b0;
         s_d.tap = {{(NUM_TAP-1){1'b0}}, 1'b1};
      end else if (ce) begin
         if (s_q.gap) begin
            s_d.gap = 1'b0;
            s_d.tap = {{(NUM_TAP-1){1'b0}}, 1'b1} << s_q.cur;
         end else if (position != s_q.cur) begin
            s_d.cur = position;
            s_d.gap = 1'b1;
            s_d.tap = '0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
   end

   assign tap_on = s_q.tap;

endmodule

/* File: logic/dwpc_top.sv */
// dual wiper position control: two-wire slave, registers, tap decode
`timescale 1ns/1ps
module dwpc_top
   import dwpc_pkg::*;
#(
   parameter int         NV_CYCLES = NV_WRITE_CYCLES, // nonvolatile write busy time
   parameter logic [3:0] DEV_ID    = 4'hc             // type nibble, value arbitrary
)(
   input  wire logic               clk_sys,            // system clock, 40 MHz
   input  wire logic               rst,                // reset, active high; sync on the system side, async on the link side
   input  wire logic               ce,                 // clock enable, system domain
   input  wire logic               scl_clk,            // serial clock from master
   input  wire logic               sda_in,             // serial data line level
   output logic                    sda_out,            // serial data drive value
   output logic                    sda_oe,             // serial data drive enable
   input  wire logic [3:0]         address_strap_pins, // low address nibble
   input  wire logic               write_guard_n,      // blocks nv writes when low
   output logic      [7:0]         wiper_position_ch0, // channel 0 position
   output logic      [7:0]         wiper_position_ch1, // channel 1 position
   output logic      [NUM_TAP-1:0] tap_on_ch0,         // channel 0 tap switches
   output logic      [NUM_TAP-1:0] tap_on_ch1,         // channel 1 tap switches
   output logic                    nv_busy             // nonvolatile write running
);

   localparam int CW = $clog2(NV_CYCLES + 1);

   // ==========================================================
   // clocking overview
   // two domains: scl_clk runs the link, clk_sys runs the registers
   // link to system: command, start and stop travel as toggles through
   // three-flop chains, so only a settled change reaches the registers
   // system to link: busy crosses through two scl-clocked flops before use
   // readback is taken straight from the system registers; this is safe
   // only because they move after a stop, never while a read byte runs
   // limitation: the link state machine only sees a stop at the next
   // falling serial clock edge, usually the one that ends the next start
   // strap pins are sampled on falling edges and settle after two serial
   // clocks, so straps should only change between commands
   // trade-off: wiper writes charge no busy time, only stored slot writes
   // a command seen while busy is dropped rather than queued, which keeps
   // the system side free of any command buffer

   // ==========================================================
   // state types

   typedef struct packed {
      logic [NUM_CH-1:0][7:0]               wiper;
      logic [NUM_CH-1:0][NUM_SLOT-1:0][7:0] dr;
      logic                                 recall;
      logic [2:0]                           cmd_s;
      logic [2:0]                           stop_s;
      logic [2:0]                           start_s;
      logic [1:0]                           wg_s;
      logic                                 armed;
      logic [15:0]                          word;
      logic [CW-1:0]                        cnt;
      logic                                 busy;
   } dwpc_sys_t;

   typedef struct packed {
      dwpc_lst_t  st;
      logic [3:0] bits;
      logic [7:0] sh;
      logic       ack;
      logic       drive;
      logic [7:0] instr;
      logic [7:0] data;
      logic       cmd_tog;
      logic       start_tog;
      logic       stop_ack;
      logic [1:0] busy_s;
      logic [3:0] strap_s0;
      logic [3:0] strap_s1;
   } dwpc_link_t;

   dwpc_sys_t  s_q;
   dwpc_sys_t  s_d;
   dwpc_link_t l_q;
   dwpc_link_t l_d;
   logic       sda_rise_q;
   logic       stop_tog_q;

   // ==========================================================
   // line conditions

   // data sampled on the rising serial clock edge
   always_ff @(posedge scl_clk or posedge rst) begin
      if (rst) begin
         sda_rise_q <= 1'b1;
      end else begin
         sda_rise_q <= sda_in;
      end
   end

   // a stop leaves the clock high, so only a data edge can see it
   always_ff @(posedge sda_in or posedge rst) begin
      if (rst) begin
         stop_tog_q <= 1'b0;
      end else if (scl_clk) begin
         stop_tog_q <= ~stop_tog_q;
      end
   end

   // ==========================================================
   // link side, advancing on the falling serial clock edge

   logic       stop_seen;
   logic       start_now;
   logic [7:0] rx_byte;
   logic [3:0] op;
   logic       instr_ok;
   logic [7:0] rd_byte;

   // start is data high at the rise and low at the fall; stop comes from the data-edge toggle
   assign stop_seen = stop_tog_q != l_q.stop_ack;
   assign start_now = (sda_rise_q | stop_seen) & ~sda_in;
   assign rx_byte   = {l_q.sh[6:0], sda_rise_q};
   assign op        = l_q.instr[OP_MSB:OP_LSB];

   // opcode check; global forms must name pot zero
   always_comb begin
      unique case (rx_byte[OP_MSB:OP_LSB])
         OP_RD_WCR, OP_WR_WCR, OP_RD_DR, OP_WR_DR,
         OP_DR_TO_WCR, OP_WCR_TO_DR: instr_ok = ~rx_byte[ZERO_BIT];
         OP_G_DR_TO_WCR, OP_G_WCR_TO_DR:
            instr_ok = ~rx_byte[ZERO_BIT] & ~rx_byte[POT_BIT];
         default: instr_ok = 1'b0;
      endcase
   end

   // readback: registers only move after a completed command, long before
   // the next read byte starts, so they are quasi-static here
   always_comb begin
      if (op == OP_RD_WCR) begin
         rd_byte = s_q.wiper[l_q.instr[POT_BIT]];
      end else begin
         rd_byte = s_q.dr[l_q.instr[POT_BIT]][l_q.instr[SLOT_MSB:SLOT_LSB]];
      end
   end

   // link state machine
   always_comb begin
      l_d          = l_q;
      l_d.busy_s   = {l_q.busy_s[0], s_q.busy};
      l_d.strap_s0 = address_strap_pins;
      l_d.strap_s1 = l_q.strap_s0;
      l_d.stop_ack = stop_tog_q;
      if (start_now) begin
         l_d.st        = L_ADDR;
         l_d.bits      = 4'h0;
         l_d.ack       = 1'b0;
         l_d.start_tog = ~l_q.start_tog;
      end else if (stop_seen) begin
         l_d.st  = L_IDLE;
         l_d.ack = 1'b0;
      end else if (l_q.ack) begin
         // ninth clock done: release and move on
         l_d.ack  = 1'b0;
         l_d.bits = 4'h0;
         unique case (l_q.st)
            L_ADDR: l_d.st = L_INSTR;
            L_INSTR: begin
               if (op == OP_WR_WCR || op == OP_WR_DR) begin
                  l_d.st = L_DRX;
               end else if (op == OP_RD_WCR || op == OP_RD_DR) begin
                  l_d.st   = L_TX;
                  l_d.sh   = rd_byte;
                  l_d.bits = 4'h1;
               end else begin
                  l_d.st      = L_IGN;
                  l_d.cmd_tog = ~l_q.cmd_tog;
               end
            end
            default: begin
               l_d.st      = L_IGN;
               l_d.cmd_tog = ~l_q.cmd_tog;
            end
         endcase
      end else begin
         unique case (l_q.st)
            L_TX: begin
               // master's acknowledge slot after the eighth bit is ignored
               if (l_q.bits == 4'(BYTE_BITS)) begin
                  l_d.st = L_IGN;
               end else begin
                  l_d.sh   = {l_q.sh[6:0], 1'b0};
                  l_d.bits = l_q.bits + 4'h1;
               end
            end
            L_ADDR, L_INSTR, L_DRX: begin
               l_d.sh   = rx_byte;
               l_d.bits = l_q.bits + 4'h1;
               if (l_q.bits == 4'(BYTE_BITS - 1)) begin
                  if (l_q.st == L_ADDR) begin
                     // busy hides the device so the master can poll
                     if (rx_byte == {DEV_ID, l_q.strap_s1} &&
                         !l_q.busy_s[1]) begin
                        l_d.ack = 1'b1;
                     end else begin
                        l_d.st = L_IGN;
                     end
                  end else if (l_q.st == L_INSTR) begin
                     l_d.instr = rx_byte;
                     l_d.ack   = instr_ok;
                     if (!instr_ok) begin
                        l_d.st = L_IGN;
                     end
                  end else begin
                     l_d.data = rx_byte;
                     l_d.ack  = 1'b1;
                  end
               end
            end
            L_IDLE, L_IGN: l_d.st = l_q.st;
            default: l_d.st = L_IDLE;
         endcase
      end
      // only ever pull low; a one releases the line
      l_d.drive = l_d.ack | ((l_d.st == L_TX) & ~l_d.sh[7]);
   end

   // link register; the clock may stand still, so reset does not wait on it
   always_ff @(negedge scl_clk or posedge rst) begin
      if (rst) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = l_q.drive;

   // ==========================================================
   // system side: registers and command execution

   logic       cmd_ev;
   logic       stop_ev;
   logic       start_ev;
   logic [3:0] x_op;
   logic [1:0] x_slot;
   logic       x_pot;
   logic [7:0] x_data;
   logic       wg_ok;

   assign cmd_ev   = s_q.cmd_s[2] ^ s_q.cmd_s[1];
   assign stop_ev  = s_q.stop_s[2] ^ s_q.stop_s[1];
   assign start_ev = s_q.start_s[2] ^ s_q.start_s[1];
   assign x_op     = s_q.word[8+OP_MSB:8+OP_LSB];
   assign x_slot   = s_q.word[8+SLOT_MSB:8+SLOT_LSB];
   assign x_pot    = s_q.word[8+POT_BIT];
   assign x_data   = s_q.word[7:0];
   assign wg_ok    = s_q.wg_s[1];

   // a finished command is armed, and runs only when its stop arrives
   always_comb begin
      s_d = s_q;
      if (rst) begin
         s_d        = '0;
         s_d.recall = 1'b1;
         for (int c = 0; c < NUM_CH; c++) begin
            s_d.wiper[c] = WCR_RESET;
            for (int k = 0; k < NUM_SLOT; k++) begin
               s_d.dr[c][k] = DR_RESET;
            end
         end
      end else if (ce) begin
         s_d.cmd_s   = {s_q.cmd_s[1:0], l_q.cmd_tog};
         s_d.stop_s  = {s_q.stop_s[1:0], stop_tog_q};
         s_d.start_s = {s_q.start_s[1:0], l_q.start_tog};
         s_d.wg_s    = {s_q.wg_s[0], write_guard_n};
         if (s_q.recall) begin
            s_d.recall = 1'b0;
            for (int c = 0; c < NUM_CH; c++) begin
               s_d.wiper[c] = s_q.dr[c][0];
            end
         end
         if (s_q.busy) begin
            if (s_q.cnt == '0) begin
               s_d.busy = 1'b0;
            end else begin
               s_d.cnt = s_q.cnt - CW'(1);
            end
         end
         if (start_ev) begin
            s_d.armed = 1'b0;
         end
         if (cmd_ev) begin
            s_d.armed = 1'b1;
            s_d.word  = {l_q.instr, l_q.data};
         end
         if (stop_ev && s_q.armed && !s_q.busy) begin
            s_d.armed = 1'b0;
            unique case (x_op)
               OP_WR_WCR: s_d.wiper[x_pot] = x_data;
               OP_DR_TO_WCR: s_d.wiper[x_pot] = s_q.dr[x_pot][x_slot];
               OP_G_DR_TO_WCR: begin
                  for (int c = 0; c < NUM_CH; c++) begin
                     s_d.wiper[c] = s_q.dr[c][x_slot];
                  end
               end
               OP_WR_DR, OP_WCR_TO_DR, OP_G_WCR_TO_DR: begin
                  // guard low drops the write and starts no busy time
                  if (wg_ok) begin
                     s_d.busy = 1'b1;
                     s_d.cnt  = CW'(NV_CYCLES - 1);
                     for (int c = 0; c < NUM_CH; c++) begin
                        if (x_op == OP_G_WCR_TO_DR) begin
                           s_d.dr[c][x_slot] = s_q.wiper[c];
                        end else if (c == int'(x_pot)) begin
                           s_d.dr[c][x_slot] = (x_op == OP_WR_DR) ?
                                               x_data : s_q.wiper[c];
                        end
                     end
                  end
               end
               default: s_d.armed = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
   end

   assign nv_busy = s_q.busy;

   // ==========================================================
   // per-channel tap decode

   logic [NUM_CH-1:0][NUM_TAP-1:0] taps;

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      dwpc_tap_decode u_tap (
         .clk_sys  (clk_sys),
         .rst      (rst),
         .ce       (ce),
         .position (s_q.wiper[c]),
         .tap_on   (taps[c])
      );
   end

   assign tap_on_ch0         = taps[0];
   assign tap_on_ch1         = taps[1];
   assign wiper_position_ch0 = s_q.wiper[0];
   assign wiper_position_ch1 = s_q.wiper[1];

endmodule

/* File: testbench/dwpc_monitor.sv */
// checker for the dual wiper position control block ports
`timescale 1ns/1ps
module dwpc_monitor
   import dwpc_pkg::*;
#(
   parameter int NV_CYCLES = NV_WRITE_CYCLES // nonvolatile busy time
)(
   input wire logic               clk_sys,            // system clock
   input wire logic               rst,                // sync reset
   input wire logic               scl_clk,            // serial clock
   input wire logic               sda_out,            // data drive value
   input wire logic               sda_oe,             // data drive enable
   input wire logic               write_guard_n,      // nv write guard
   input wire logic [7:0]         wiper_position_ch0, // position 0
   input wire logic [7:0]         wiper_position_ch1, // position 1
   input wire logic [NUM_TAP-1:0] tap_on_ch0,         // taps 0
   input wire logic [NUM_TAP-1:0] tap_on_ch1,         // taps 1
   input wire logic               nv_busy             // nv write running
);
   logic [31:0] busy_cnt_q; // length of the current busy run

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ==========================================================
   // helper: busy run length, cleared whenever busy is low
   always_ff @(posedge clk_sys) begin
      if (rst || !nv_busy)
         busy_cnt_q <= 32'h0;
      else
         busy_cnt_q <= busy_cnt_q + 32'h1;
   end

   // ==========================================================
   // settled wiper: three samples without change, gap cycle passed
   sequence s_hold0;
      $stable(wiper_position_ch0)[*3];
   endsequence
   sequence s_hold1;
      $stable(wiper_position_ch1)[*3];
   endsequence

   a_sda_drive_low: assert property (sda_out == 1'b0)
      else $error("data line driven high");
   a_sda_change_low: assert property (scl_clk && $past(scl_clk) |-> $stable(sda_oe))
      else $error("data drive changed while serial clock high");
   a_taps_onehot0: assert property ($onehot0(tap_on_ch0))
      else $error("channel 0 has several taps on");
   a_taps_onehot1: assert property ($onehot0(tap_on_ch1))
      else $error("channel 1 has several taps on");
   // a tap may only move through the all-off state
   a_break_make: assert property ($changed(tap_on_ch0) |->
      (tap_on_ch0 == '0 || $past(tap_on_ch0) == '0))
      else $error("channel 0 tap moved without a gap");
   a_tap_decode0: assert property (s_hold0 |->
      tap_on_ch0 == ({{(NUM_TAP-1){1'b0}}, 1'b1} << wiper_position_ch0))
      else $error("channel 0 tap does not match position");
   a_tap_decode1: assert property (s_hold1 |->
      tap_on_ch1 == ({{(NUM_TAP-1){1'b0}}, 1'b1} << wiper_position_ch1))
      else $error("channel 1 tap does not match position");
   a_busy_length: assert property ($fell(nv_busy) |->
      busy_cnt_q inside {[NV_CYCLES-1:NV_CYCLES+1]})
      else $error("nonvolatile busy time wrong");
   a_guard_blocks: assert property ((!write_guard_n)[*4] |-> !$rose(nv_busy))
      else $error("nonvolatile write started while guarded");
endmodule

bind dwpc_top dwpc_monitor #(.NV_CYCLES(NV_CYCLES)) u_mon (
   .clk_sys(clk_sys), .rst(rst), .scl_clk(scl_clk), .sda_out(sda_out),
   .sda_oe(sda_oe), .write_guard_n(write_guard_n),
   .wiper_position_ch0(wiper_position_ch0), .wiper_position_ch1(wiper_position_ch1),
   .tap_on_ch0(tap_on_ch0), .tap_on_ch1(tap_on_ch1), .nv_busy(nv_busy));

/* File: testbench/dwpc_master.sv */
// two-wire bus master model; clock idles high between frames
`timescale 1ns/1ps
module dwpc_master (
   output logic      scl_clk,  // serial clock, 64 ns period in frames
   output logic      sda_pull, // high pulls the data wire low
   input  wire logic sda       // resolved data wire
);
   initial begin
      scl_clk = 1'b1;
      sda_pull = 1'b0;
   end

   // ==========================================================
   // one bit: data moves in the low half, wire taken at the rise
   task automatic bit_cyc(input logic b, output logic s);
      #8 sda_pull = !b;
      #24 s = sda;
      scl_clk = 1'b1;
      #32 scl_clk = 1'b0;
   endtask

   // opening condition, also serves as repeated start
   task automatic start();
      #8 sda_pull = 1'b0;
      #8 scl_clk = 1'b1;
      #16 sda_pull = 1'b1;
      #16 scl_clk = 1'b0;
   endtask

   // closing condition; clock then stands still high
   task automatic stop();
      #8 sda_pull = 1'b1;
      #24 scl_clk = 1'b1;
      #16 sda_pull = 1'b0;
      #32;
   endtask

   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
      bit_cyc(1'b1, s);
      ack = !s;
   endtask

   // read one byte, then refuse more by leaving the ninth bit high
   task automatic get(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b1, s);
         d[i] = s;
      end
      bit_cyc(1'b1, s);
   endtask
endmodule

/* File: testbench/tb_dual_wiper_position_control.sv */
// self-checking bench for the dual wiper position control block
`timescale 1ns/1ps
module tb_dual_wiper_position_control;
   import dwpc_pkg::*;
   localparam int         NV_SIM = 50;   // shortened busy time
   localparam logic [3:0] ID_NIB = 4'h3; // type nibble, value arbitrary

   logic               clk_sys;
   logic               rst;
   logic               ce;
   logic [3:0]         straps;
   logic               guard_n;
   logic               scl_clk;
   logic               sda_pull;
   logic               sda_out;
   logic               sda_oe;
   logic [7:0]         pos [2];
   logic [NUM_TAP-1:0] tap [2];
   logic               nv_busy;
   logic [7:0]         tgt;
   logic [7:0]         wexp [2];
   logic [7:0]         dexp [2][4];
   int                 err_total;
   int                 comparisons;
   wire                sda_wire = !(sda_pull || (sda_oe && !sda_out)); // pull-up

   initial clk_sys = 1'b0;
   always #12.5 clk_sys = ~clk_sys;

   dwpc_master u_mst (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda(sda_wire));

   dwpc_top #(.NV_CYCLES(NV_SIM), .DEV_ID(ID_NIB)) uut (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .scl_clk(scl_clk), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pins(straps),
      .write_guard_n(guard_n), .wiper_position_ch0(pos[0]), .wiper_position_ch1(pos[1]),
      .tap_on_ch0(tap[0]), .tap_on_ch1(tap[1]), .nv_busy(nv_busy));

   // ==========================================================
   // expectations and checks
   function automatic logic [7:0] ins(input logic [3:0] op, input logic [1:0] sl,
                                      input logic p);
      return {op, sl, 1'b0, p};
   endfunction

   function automatic logic [NUM_TAP-1:0] onehot(input logic [7:0] p);
      return {{(NUM_TAP-1){1'b0}}, 1'b1} << p;
   endfunction

   task automatic stop_test();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one framed command; mode 0 bare, 1 data byte out, 2 byte read
   task automatic cmd(input logic [7:0] i, input logic [7:0] d, input int mode,
                      output logic [2:0] a, output logic [7:0] r);
      a = 3'b000;
      r = 8'h00;
      u_mst.start();
      u_mst.put(tgt, a[2]);
      if (a[2]) u_mst.put(i, a[1]);
      if (a[1] && mode == 1) u_mst.put(d, a[0]);
      if (a[1] && mode == 2) u_mst.get(r);
      u_mst.stop();
   endtask

   // wait for both wipers, then let the tap gap pass before checking
   task automatic settle();
      int n;
      n = 0;
      while (n < 40 && !(pos[0] === wexp[0] && pos[1] === wexp[1])) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n == 40) begin
         err_total++;
         stop_test();
      end
      repeat (3) @(posedge clk_sys);
      #1;
      for (int c = 0; c < 2; c++) begin
         chk(pos[c], wexp[c]);
         chk({7'h0, tap[c] === onehot(wexp[c])}, 8'h01);
      end
   endtask

   // address-only polling; the first poll tells whether a write runs
   task automatic nv_wait(input logic busy_exp);
      logic a;
      int   n;
      n = 0;
      do begin
         u_mst.start();
         u_mst.put(tgt, a);
         u_mst.stop();
         if (n == 0) chk({7'h0, a}, {7'h0, !busy_exp});
         n++;
      end while (!a && n < 20);
      if (!a) begin
         err_total++;
         stop_test();
      end
   endtask

   task automatic set_pos(input logic p, input logic [7:0] v);
      logic [2:0] a;
      logic [7:0] r;
      cmd(ins(4'ha, 2'b00, p), v, 1, a, r);
      chk({5'h0, a}, 8'h07);
      wexp[p] = v;
      settle();
      cmd(ins(4'h9, 2'b00, p), 8'h00, 2, a, r);
      chk(r, v);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [2:0] a;
      logic [7:0] r;
      logic [7:0] v;
      err_total = 0;
      comparisons = 0;
      rst = 1'b1;
      ce = 1'b1;
      guard_n = 1'b1;
      void'($urandom(32'h64fc));
      straps = 4'($urandom);
      tgt = {ID_NIB, straps};
      wexp = '{DR_RESET, DR_RESET};
      dexp = '{default: DR_RESET};
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      settle();
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         set_pos(i[0], v);
      end
      // foreign address: nothing may answer or change
      tgt = {ID_NIB, straps ^ 4'h8};
      cmd(ins(4'ha, 2'b00, 1'b0), 8'h33, 1, a, r);
      chk({5'h0, a}, 8'h00);
      // reserved bit set: address taken, instruction refused
      tgt = {ID_NIB, straps};
      cmd(8'h92, 8'h00, 2, a, r);
      chk({5'h0, a}, 8'h04);
      settle();
      @(posedge clk_sys);
      straps <= straps + 4'h5;
      @(posedge clk_sys);
      tgt = {ID_NIB, straps};
      for (int s = 0; s < 4; s++) begin
         v = 8'($urandom);
         cmd(ins(4'hc, 2'(s), s[0]), v, 1, a, r);
         chk({5'h0, a}, 8'h07);
         dexp[s[0]][s] = v;
         nv_wait(1'b1);
         cmd(ins(4'hb, 2'(s), s[0]), 8'h00, 2, a, r);
         chk(r, v);
         cmd(ins(4'hd, 2'(s), s[0]), 8'h00, 0, a, r);
         wexp[s[0]] = v;
         settle();
      end
      // single and global copies of the wipers into stored slots
      cmd(ins(4'he, 2'b10, 1'b1), 8'h00, 0, a, r);
      dexp[1][2] = wexp[1];
      nv_wait(1'b1);
      cmd(ins(4'h8, 2'b01, 1'b0), 8'h00, 0, a, r);
      dexp[0][1] = wexp[0];
      dexp[1][1] = wexp[1];
      nv_wait(1'b1);
      for (int c = 0; c < 2; c++) begin
         cmd(ins(4'hb, 2'b01, c[0]), 8'h00, 2, a, r);
         chk(r, dexp[c][1]);
      end
      cmd(ins(4'hb, 2'b10, 1'b1), 8'h00, 2, a, r);
      chk(r, dexp[1][2]);
      cmd(ins(4'h1, 2'b00, 1'b0), 8'h00, 0, a, r);
      wexp = '{dexp[0][0], dexp[1][0]};
      settle();
      // guarded store is taken but must leave the slot alone
      @(posedge clk_sys);
      guard_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      cmd(ins(4'hc, 2'b00, 1'b0), ~dexp[0][0], 1, a, r);
      chk({5'h0, a}, 8'h07);
      nv_wait(1'b0);
      cmd(ins(4'hb, 2'b00, 1'b0), 8'h00, 2, a, r);
      chk(r, dexp[0][0]);
      @(posedge clk_sys);
      guard_n <= 1'b1;
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      wexp = '{DR_RESET, DR_RESET};
      repeat (6) @(posedge clk_sys);
      settle();
      stop_test();
   end
endmodule
